// >>> src/ais_pkg.sv
// shared constants of the analog input scaler
package ais_pkg;

   // ----------------------------------------------------------------
   // object dictionary indices
   // ----------------------------------------------------------------
   localparam logic [15:0] AIS_IDX_VALUE = 16'h3320;
   localparam logic [15:0] AIS_IDX_OFFSET = 16'h3321;
   localparam logic [15:0] AIS_IDX_MULT = 16'h3322;
   localparam logic [15:0] AIS_IDX_DIV = 16'h3323;
   localparam logic [7:0] AIS_SUB_COUNT = 8'h00;
   localparam logic [7:0] AIS_SUB_FIRST = 8'h01;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] AIS_VALUE_RST = 32'h0000_0000;
   localparam logic [15:0] AIS_OFFSET_RST = 16'h0000;
   localparam logic [15:0] AIS_MULT_RST = 16'h0001;
   localparam logic [15:0] AIS_DIV_RST = 16'h0001;
   localparam logic [31:0] AIS_RDATA_RST = 32'h0000_0000;

   // ----------------------------------------------------------------
   // widths and current conversion
   // ----------------------------------------------------------------
   localparam int AIS_ADC_W = 10;
   localparam int AIS_CFG_W = 16;
   localparam int AIS_SUM_W = 17;
   localparam int AIS_PROD_W = 33;
   localparam int AIS_OUT_W = 32;
   localparam int AIS_MAX_INPUTS = 2;
   localparam logic [15:0] AIS_CUR_FULL_MA = 16'h0014;
   localparam logic [15:0] AIS_CUR_FULL_CNT = 16'h03FF;

   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      AIS_IDLE,
      AIS_SCALE,
      AIS_WAIT_SCALE,
      AIS_WAIT_CUR
   } ais_state_e;

endpackage

// >>> src/ais_divider.sv
// signed sequential divider, quotient truncated toward zero
`timescale 1ns/10ps
module ais_divider #(
   parameter int DW = 33,
   parameter int VW = 16
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic signed [DW-1:0] dividend,
   input wire logic signed [VW-1:0] divisor,
   output logic done,
   output logic signed [DW-1:0] quotient
);
   import ais_pkg::*;

   localparam int CW = $clog2(DW + 1);

   typedef struct packed {
      logic busy;
      logic [CW-1:0] cnt;
      logic neg;
      logic [VW-1:0] dvs;
      logic [VW:0] rem;
      logic [DW-1:0] quo;
      logic done;
      logic [DW-1:0] q_out;
   } ais_div_s;

   ais_div_s st_reg;
   ais_div_s st_next;

   // ----------------------------------------------------------------
   // one restoring step per cycle on magnitudes
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [VW:0] trial;
      trial = '0;
      st_next = st_reg;
      st_next.done = 1'b0;
      if (start)
      begin
         st_next.busy = 1'b1;
         st_next.cnt = CW'(DW);
         st_next.neg = dividend[DW-1] ^ divisor[VW-1];
         st_next.quo = dividend[DW-1] ? DW'(-dividend) : dividend;
         st_next.dvs = divisor[VW-1] ? VW'(-divisor) : divisor;
         st_next.rem = '0;
      end
      else if (st_reg.busy)
      begin
         trial = {st_reg.rem[VW-1:0], st_reg.quo[DW-1]};
         st_next.quo = {st_reg.quo[DW-2:0], 1'b0};
         if (trial >= {1'b0, st_reg.dvs})
         begin
            st_next.rem = trial - {1'b0, st_reg.dvs};
            st_next.quo[0] = 1'b1;
         end
         else
         begin
            st_next.rem = trial;
         end
         st_next.cnt = st_reg.cnt - CW'(1);
         if (st_reg.cnt == CW'(1))
         begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
            st_next.q_out = st_reg.neg ? DW'(-st_next.quo) : st_next.quo;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign done = st_reg.done;
   assign quotient = st_reg.q_out;

endmodule

// >>> src/ais_scaler.sv
// analog input scaler: offset, multiply, divide and publish per input
//
// Functional notes
// - signed offset is added to raw count before multiply or divide
// - offset-corrected count is multiplied by signed multiplier
// - product divided by signed divisor; quotient is published value
// - with default settings the published value equals the raw count
// - published value signed 32-bit, read-only, zero after reset
// - read-only count entry reports number of inputs present
// - offset is signed 16-bit read-write, zero after reset
// - multiplier is signed 16-bit read-write, one after reset
// - divisor is signed 16-bit read-write, one after reset
// - optional second input has its own entries, same processing
`timescale 1ns/10ps
module ais_scaler #(
   parameter int NUM_INPUTS = 1
)
(
   input wire logic sys_clk,
   input wire logic rst,
   // converter samples, same clock domain
   input wire logic adc_valid,
   input wire logic [0:0] adc_chan,
   input wire logic [ais_pkg::AIS_ADC_W-1:0] adc_raw,
   input wire logic [NUM_INPUTS-1:0] current_mode,
   // object dictionary access
   input wire logic od_rd,
   input wire logic od_wr,
   input wire logic [15:0] od_index,
   input wire logic [7:0] od_sub,
   input wire logic [31:0] od_wdata,
   output logic [31:0] od_rdata,
   output logic od_ack,
   output logic od_err,
   // published results
   output logic [NUM_INPUTS*ais_pkg::AIS_OUT_W-1:0] scaled_value,
   output logic [NUM_INPUTS*ais_pkg::AIS_OUT_W-1:0] current_ma,
   output logic busy
);
   import ais_pkg::*;

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   generate
      if (NUM_INPUTS < 1 || NUM_INPUTS > AIS_MAX_INPUTS)
      begin : g_bad_inputs
         $error("NUM_INPUTS must be 1 or 2");
      end
   endgenerate

   localparam logic [7:0] COUNT_VAL = 8'(NUM_INPUTS);

   typedef struct packed {
      ais_state_e state;
      logic [0:0] ch;
      logic [NUM_INPUTS-1:0] pending;
      logic [NUM_INPUTS-1:0][AIS_ADC_W-1:0] raw;
      logic [NUM_INPUTS-1:0][AIS_CFG_W-1:0] offset;
      logic [NUM_INPUTS-1:0][AIS_CFG_W-1:0] mult;
      logic [NUM_INPUTS-1:0][AIS_CFG_W-1:0] div;
      logic [NUM_INPUTS-1:0][AIS_OUT_W-1:0] value;
      logic [NUM_INPUTS-1:0][AIS_OUT_W-1:0] cur;
      logic div_start;
      logic signed [AIS_PROD_W-1:0] div_num;
      logic signed [AIS_CFG_W-1:0] div_den;
      logic [31:0] rdata;
      logic ack;
      logic err;
      logic busy;
   } ais_scaler_s;

   ais_scaler_s st_reg;
   ais_scaler_s st_next;

   logic div_done;
   logic signed [AIS_PROD_W-1:0] div_quo;

   // ----------------------------------------------------------------
   // shared divider
   // ----------------------------------------------------------------
   ais_divider #(
      .DW(AIS_PROD_W),
      .VW(AIS_CFG_W)
   )
   u_div
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(st_reg.div_start),
      .dividend(st_reg.div_num),
      .divisor(st_reg.div_den),
      .done(div_done),
      .quotient(div_quo)
   );

   // ----------------------------------------------------------------
   // sequencer and register access
   // ----------------------------------------------------------------
   always_comb
   begin
      logic signed [AIS_SUM_W-1:0] sum;
      logic signed [AIS_PROD_W-1:0] prod;
      logic [7:0] sel;
      logic hit;
      sum = '0;
      prod = '0;
      sel = '0;
      hit = 1'b0;
      st_next = st_reg;
      st_next.div_start = 1'b0;
      st_next.ack = 1'b0;

      // capture a new sample; a fresh one replaces a waiting one
      if (adc_valid && (int'(adc_chan) < NUM_INPUTS))
      begin
         st_next.raw[adc_chan] = adc_raw;
         st_next.pending[adc_chan] = 1'b1;
      end

      case (st_reg.state)
         AIS_IDLE:
         begin
            if (st_reg.pending[0])
            begin
               st_next.ch = 1'b0;
               st_next.state = AIS_SCALE;
            end
            else if (st_reg.pending[NUM_INPUTS-1])
            begin
               st_next.ch = 1'(NUM_INPUTS - 1);
               st_next.state = AIS_SCALE;
            end
         end
         AIS_SCALE:
         begin
            // sample taken; a newer one sets pending again
            if (!(adc_valid && adc_chan == st_reg.ch))
               st_next.pending[st_reg.ch] = 1'b0;
            sum = $signed({7'h00, st_reg.raw[st_reg.ch]})
               + $signed({st_reg.offset[st_reg.ch][15],
                  st_reg.offset[st_reg.ch]});
            prod = sum * $signed(st_reg.mult[st_reg.ch]);
            st_next.div_num = prod;
            st_next.div_den = $signed(st_reg.div[st_reg.ch]);
            if (st_reg.div[st_reg.ch] == AIS_OFFSET_RST)
            begin
               st_next.state = AIS_IDLE;
            end
            else
            begin
               st_next.div_start = 1'b1;
               st_next.state = AIS_WAIT_SCALE;
            end
         end
         AIS_WAIT_SCALE:
         begin
            if (div_done)
            begin
               st_next.value[st_reg.ch] = div_quo[AIS_OUT_W-1:0];
               if (current_mode[st_reg.ch])
               begin
                  // count times 20 over 1023 for current inputs
                  st_next.div_num = $signed({23'h000000,
                     st_reg.raw[st_reg.ch]}) * $signed({1'b0,
                     AIS_CUR_FULL_MA});
                  st_next.div_den = $signed(AIS_CUR_FULL_CNT);
                  st_next.div_start = 1'b1;
                  st_next.state = AIS_WAIT_CUR;
               end
               else
               begin
                  st_next.state = AIS_IDLE;
               end
            end
         end
         AIS_WAIT_CUR:
         begin
            if (div_done)
            begin
               st_next.cur[st_reg.ch] = div_quo[AIS_OUT_W-1:0];
               st_next.state = AIS_IDLE;
            end
         end
         default:
         begin
            st_next.state = AIS_IDLE;
         end
      endcase
      st_next.busy = (st_next.state != AIS_IDLE);

      // object dictionary access, answered one cycle later
      sel = od_sub - AIS_SUB_FIRST;
      if (od_rd || od_wr)
      begin
         st_next.ack = 1'b1;
         st_next.err = 1'b0;
         st_next.rdata = AIS_RDATA_RST;
         hit = (od_sub != AIS_SUB_COUNT) && (int'(sel) < NUM_INPUTS);
         if (od_index != AIS_IDX_VALUE && od_index != AIS_IDX_OFFSET
            && od_index != AIS_IDX_MULT && od_index != AIS_IDX_DIV)
         begin
            st_next.err = 1'b1;
         end
         else if (od_sub == AIS_SUB_COUNT)
         begin
            st_next.rdata = {24'h000000, COUNT_VAL};
            st_next.err = od_wr;
         end
         else if (!hit)
         begin
            st_next.err = 1'b1;
         end
         else if (od_index == AIS_IDX_VALUE)
         begin
            st_next.rdata = st_reg.value[sel[0:0]];
            st_next.err = od_wr;
         end
         else if (od_index == AIS_IDX_OFFSET)
         begin
            st_next.rdata = {{16{st_reg.offset[sel[0:0]][15]}},
               st_reg.offset[sel[0:0]]};
            if (od_wr)
               st_next.offset[sel[0:0]] = od_wdata[15:0];
         end
         else if (od_index == AIS_IDX_MULT)
         begin
            st_next.rdata = {{16{st_reg.mult[sel[0:0]][15]}},
               st_reg.mult[sel[0:0]]};
            if (od_wr)
               st_next.mult[sel[0:0]] = od_wdata[15:0];
         end
         else
         begin
            st_next.rdata = {{16{st_reg.div[sel[0:0]][15]}},
               st_reg.div[sel[0:0]]};
            if (od_wr)
               st_next.div[sel[0:0]] = od_wdata[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // state register with documented reset values
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_reg <= '0;
         st_reg.state <= AIS_IDLE;
         for (int i = 0; i < NUM_INPUTS; i++)
         begin
            st_reg.offset[i] <= AIS_OFFSET_RST;
            st_reg.mult[i] <= AIS_MULT_RST;
            st_reg.div[i] <= AIS_DIV_RST;
            st_reg.value[i] <= AIS_VALUE_RST;
         end
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs straight from the state register
   // ----------------------------------------------------------------
   assign od_rdata = st_reg.rdata;
   assign od_ack = st_reg.ack;
   assign od_err = st_reg.err;
   assign scaled_value = st_reg.value;
   assign current_ma = st_reg.cur;
   assign busy = st_reg.busy;

endmodule

// >>> verification/ais_adc_model.sv
// converter model feeding samples into the scaler
`timescale 1ns/10ps
module ais_adc_model (
   input wire logic sys_clk,
   output logic adc_valid,
   output logic [0:0] adc_chan,
   output logic [ais_pkg::AIS_ADC_W-1:0] adc_raw
);
   import ais_pkg::*;
   initial
   begin
      adc_valid = 1'b0;
      adc_chan = 1'b0;
      adc_raw = '0;
   end
   // one-cycle strobe; data lines go stale (inverted) once it drops
   task automatic send(input logic [AIS_ADC_W-1:0] r);
      @(negedge sys_clk);
      adc_valid <= 1'b1;
      adc_raw <= r;
      @(negedge sys_clk);
      adc_valid <= 1'b0;
      adc_raw <= ~r;
   endtask
endmodule

// >>> verification/ais_scaler_sva.sv
// port assertions for the analog input scaler
`timescale 1ns/10ps
module ais_scaler_sva #(
   parameter int NUM_INPUTS = 1
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic adc_valid,
   input wire logic [0:0] adc_chan,
   input wire logic [ais_pkg::AIS_ADC_W-1:0] adc_raw,
   input wire logic [NUM_INPUTS-1:0] current_mode,
   input wire logic od_rd,
   input wire logic od_wr,
   input wire logic [15:0] od_index,
   input wire logic [7:0] od_sub,
   input wire logic [31:0] od_wdata,
   input wire logic [31:0] od_rdata,
   input wire logic od_ack,
   input wire logic od_err,
   input wire logic [NUM_INPUTS*ais_pkg::AIS_OUT_W-1:0] scaled_value,
   input wire logic [NUM_INPUTS*ais_pkg::AIS_OUT_W-1:0] current_ma,
   input wire logic busy
);
   import ais_pkg::*;
   logic req;
   logic known;
   // request strobe and mapped-index flag
   assign req = od_rd | od_wr;
   assign known = od_index inside {[AIS_IDX_VALUE:AIS_IDX_DIV]};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   a_ack_follows: assert property (req |=> od_ack)
      else $error("request not answered");
   a_ack_cause: assert property (od_ack |-> $past(req))
      else $error("answer without request");
   a_hold_answer: assert property (!$past(req) |-> $stable(od_rdata)
      && $stable(od_err)) else $error("answer changed without request");
   a_value_ro: assert property (od_wr && od_index == AIS_IDX_VALUE
      |=> od_ack && od_err) else $error("value write accepted");
   a_count_ro: assert property (od_wr && od_sub == AIS_SUB_COUNT
      |=> od_err) else $error("count write accepted");
   a_count_value: assert property (od_rd && !od_wr && known
      && od_sub == AIS_SUB_COUNT |=> od_rdata == 32'(NUM_INPUTS) && !od_err)
      else $error("wrong entry count");
   a_unmapped_err: assert property (od_rd && !od_wr
      && (!known || od_sub > NUM_INPUTS) |=> od_err && od_rdata == 32'h0)
      else $error("unmapped read not refused");
   // ----------------------------------------------------------------
   // computation
   // ----------------------------------------------------------------
   a_value_cause: assert property ($changed(scaled_value) |-> $past(busy))
      else $error("value changed outside computation");
   a_busy_bound: assert property ($rose(busy) |-> ##[1:120] !busy)
      else $error("computation never ends");
endmodule

// >>> verification/tb.sv
// self-checking bench for the analog input scaler
`timescale 1ns/10ps
module tb;
   import ais_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic adc_valid, od_ack, od_err, busy, busy_q;
   logic [0:0] adc_chan;
   logic [AIS_ADC_W-1:0] adc_raw;
   logic [0:0] current_mode = 1'b0;
   logic od_rd = 1'b0;
   logic od_wr = 1'b0;
   logic [15:0] od_index = 16'h0000;
   logic [7:0] od_sub = 8'h00;
   logic [31:0] od_wdata = 32'h0000_0000;
   logic [31:0] od_rdata, scaled_value, current_ma;
   logic [32:0] rq[$];
   logic [31:0] sq[$];
   logic signed [15:0] off, mul, dv, nv;
   logic [31:0] val;
   int err_total = 0;
   int comparisons = 0;
   int seed = 32'h5486;
   int i, t;
   always #5 sys_clk = ~sys_clk;
   ais_adc_model adc (.sys_clk(sys_clk), .adc_valid(adc_valid),
      .adc_chan(adc_chan), .adc_raw(adc_raw));
   ais_scaler #(.NUM_INPUTS(1)) uut (.sys_clk(sys_clk), .rst(rst),
      .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_raw(adc_raw),
      .current_mode(current_mode), .od_rd(od_rd), .od_wr(od_wr),
      .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata),
      .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err),
      .scaled_value(scaled_value), .current_ma(current_ma), .busy(busy));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("compares %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic fail(input string m);
      err_total++;
      $display("ERROR %0t %s", $time, m);
   endtask
   // answer to a 16-bit entry: no error flag, data sign-extended
   function automatic logic [32:0] sx(input logic [15:0] x);
      return {1'b0, {16{x[15]}}, x};
   endfunction
   function automatic logic [31:0] scale(input logic [9:0] r);
      longint p;
      p = (longint'(r) + off) * mul;
      return 32'(p / dv);
   endfunction
   // one register request, expectation noted for the monitor
   task automatic acc(input logic w, input logic [15:0] x,
      input logic [7:0] s, input logic [15:0] d, input logic [32:0] e);
      @(negedge sys_clk);
      od_rd <= ~w;
      od_wr <= w;
      od_index <= x;
      od_sub <= s;
      od_wdata <= {16'($random(seed)), d};
      rq.push_back(e);
   endtask
   // release the port, then bounded wait for every answer
   task automatic drain();
      @(negedge sys_clk);
      od_rd <= 1'b0;
      od_wr <= 1'b0;
      for (t = 0; t < 20 && rq.size() != 0; t++)
         @(negedge sys_clk);
      if (t == 20)
      begin
         fail("answer timeout");
         conclude();
      end
   endtask
   // one sample, then bounded wait for the computation to settle
   task automatic sample(input logic [9:0] r);
      if (dv != 0)
      begin
         val = scale(r);
         sq.push_back(val);
      end
      adc.send(r);
      repeat (3) @(negedge sys_clk);
      for (t = 0; t < 300 && (sq.size() != 0 || busy !== 1'b0); t++)
         @(negedge sys_clk);
      if (t == 300)
      begin
         fail("compute timeout");
         conclude();
      end
      acc(0, AIS_IDX_VALUE, 1, 0, {1'b0, val});
      drain();
   endtask
   // monitor: compare each answer and each result to the oldest note
   always @(posedge sys_clk)
   begin
      busy_q <= busy;
      if (!rst && od_ack === 1'b1)
      begin
         comparisons++;
         if (rq.size() == 0)
            fail("unexpected answer");
         else if ({od_err, od_rdata} !== rq.pop_front())
            fail("register answer mismatch");
      end
      if (!rst && busy_q === 1'b1 && busy === 1'b0 && sq.size() != 0)
      begin
         comparisons++;
         if (scaled_value !== sq.pop_front())
            fail("scaled value mismatch");
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      off = 0;
      mul = 1;
      dv = 1;
      val = 0;
      repeat (6) @(negedge sys_clk);
      rst <= 1'b0;
      for (i = 0; i < 4; i++)
         acc(0, 16'(AIS_IDX_VALUE + i), 0, 0, 33'h1);
      acc(0, AIS_IDX_VALUE, 1, 0, 33'h0);
      acc(0, AIS_IDX_OFFSET, 1, 0, 33'h0);
      acc(0, AIS_IDX_MULT, 1, 0, 33'h1);
      acc(0, AIS_IDX_DIV, 1, 0, 33'h1);
      acc(0, AIS_IDX_DIV, 2, 0, 33'h1_0000_0000);
      acc(0, 16'h3324, 1, 0, 33'h1_0000_0000);
      acc(1, AIS_IDX_VALUE, 1, 16'h1234, 33'h1_0000_0000);
      acc(1, AIS_IDX_MULT, 0, 16'h1234, 33'h1_0000_0001);
      drain();
      $display("test reset and map done");
      sample(10'($random(seed)));
      sample(10'h3FF);
      $display("test defaults done");
      for (i = 0; i < 8; i++)
      begin
         nv = 16'($random(seed) % 600);
         acc(1, AIS_IDX_OFFSET, 1, nv, sx(off));
         off = nv;
         nv = 16'($random(seed) % 90);
         acc(1, AIS_IDX_MULT, 1, nv, sx(mul));
         mul = nv;
         nv = (i == 0) ? 16'hFFFF : 16'($random(seed) % 40);
         nv = (nv == 0) ? 16'h0007 : nv;
         acc(1, AIS_IDX_DIV, 1, nv, sx(dv));
         dv = nv;
         drain();
         sample(10'($random(seed)));
      end
      $display("test scaling done");
      acc(1, AIS_IDX_DIV, 1, 16'h0000, sx(dv));
      dv = 0;
      drain();
      sample(10'h155);
      $display("test zero divisor done");
      current_mode <= 1'b1;
      acc(1, AIS_IDX_DIV, 1, 16'h0001, 33'h0);
      dv = 1;
      drain();
      sample(10'h3FF);
      for (t = 0; t < 200 && current_ma !== 32'd20; t++)
         @(negedge sys_clk);
      comparisons++;
      if (current_ma !== 32'd20)
         fail("current conversion mismatch");
      $display("test current done");
      rst <= 1'b1;
      repeat (2) @(negedge sys_clk);
      rst <= 1'b0;
      off = 0;
      mul = 1;
      dv = 1;
      acc(0, AIS_IDX_MULT, 1, 0, 33'h1);
      acc(0, AIS_IDX_VALUE, 1, 0, 33'h0);
      drain();
      comparisons++;
      if (scaled_value !== 32'h0 || current_ma !== 32'h0)
         fail("outputs not cleared by reset");
      $display("test second reset done");
      conclude();
   end
endmodule
bind ais_scaler ais_scaler_sva #(.NUM_INPUTS(NUM_INPUTS)) chk (
   .sys_clk(sys_clk), .rst(rst), .adc_valid(adc_valid),
   .adc_chan(adc_chan), .adc_raw(adc_raw), .current_mode(current_mode),
   .od_rd(od_rd), .od_wr(od_wr), .od_index(od_index), .od_sub(od_sub),
   .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack),
   .od_err(od_err), .scaled_value(scaled_value),
   .current_ma(current_ma), .busy(busy));
